// ===== design/uart_modem_sfr_regs.sv
// Purpose: Modem status, special function, sample clock and divisor
//          registers of one UART channel, on a byte register port.
// Assumes: Line control bit 7 arrives as line_control_dlab; FIFO
//          counters and the error counter come from elsewhere.
// Notes:   Read data is registered and valid one cycle after reg_rd.

`timescale 1ns/1ps

module uart_modem_status_and_divisor_regs
   import modem_regs_pkg::*;
(
   // Clock, reset and enable
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ce,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   // Line control bit 7
   input wire logic line_control_dlab,
   // Modem lines
   input wire logic cts,
   input wire logic dsr,
   input wire logic ri,
   input wire logic dcd,
   input wire logic dtr_manual,
   output logic dtr_out,
   // Counter sources
   input wire logic [7:0] rx_fifo_fill_count,
   input wire logic [7:0] tx_fifo_fill_count,
   input wire logic [7:0] lsr_error_count,
   input wire logic rx_near_full,
   // Baud and transmit controls
   output logic [15:0] baud_divisor,
   output logic [3:0] oversample_count,
   output logic [4:0] samples_per_bit,
   output logic force_tx,
   output logic auto_dsr_dtr_en,
   output logic enhanced_mode,
   output logic tx_allow
);

   import modem_regs_pkg::*;

   // ==========================================================
   // State
   // ==========================================================
   typedef struct packed {
      logic [7:0] div_low;
      logic [7:0] div_high;
      logic [7:0] special;
      logic [3:0] sample;
      logic [15:0] divisor;
      logic [4:0] samples;
      logic [7:0] rdata;
      logic rvalid;
   } regs_state_type;

   regs_state_type st_reg;
   regs_state_type st_next;

   localparam regs_state_type REGS_RESET = '{
      div_low: RST_DIV_BYTE,
      div_high: RST_DIV_BYTE,
      special: RST_SPECIAL,
      sample: RST_SAMPLE,
      divisor: {RST_DIV_BYTE, RST_DIV_BYTE},
      samples: SAMPLE_SIXTEEN,
      rdata: RST_RDATA,
      rvalid: 1'b0
   };

   modem_line_if mif ();

   logic [7:0] modem_status;
   logic hit_div_low;
   logic hit_div_high;
   logic hit_status;
   logic hit_special;
   logic hit_tx_view;
   logic hit_sample_alt;
   logic sample_writable;
   logic force_sel;
   logic auto_sel;
   logic rx_view_sel;
   logic tx_view_sel;
   logic wr_div_low;
   logic wr_div_high;
   logic wr_special;
   logic wr_sample;
   logic [7:0] sample_view;
   logic [7:0] rx_view;
   logic [7:0] tx_view;
   logic [7:0] read_value;
   logic [4:0] samples_value;

   // ==========================================================
   // Modem line change detection
   // ==========================================================
   assign mif.line_in[LINE_CTS] = cts;
   assign mif.line_in[LINE_DSR] = dsr;
   assign mif.line_in[LINE_RI] = ri;
   assign mif.line_in[LINE_DCD] = dcd;

   // Frozen cycles must not consume a read-clear
   assign mif.read_clear = ce && reg_rd && hit_status;

   modem_change_detect u_detect (
      .core_clk (core_clk),
      .rst (rst),
      .ce (ce),
      .mif (mif)
   );

   // ==========================================================
   // Modem status byte
   // ==========================================================
   // Upper nibble: registered levels; lower nibble: sticky flags
   assign modem_status = {mif.level, mif.delta};

   // ==========================================================
   // Special function fields
   // ==========================================================
   assign force_sel = st_reg.special[SF_FORCE_TX];
   assign auto_sel = st_reg.special[SF_AUTO_DSR_DTR];
   assign rx_view_sel = st_reg.special[SF_RX_VIEW_SEL];
   assign tx_view_sel = st_reg.special[SF_TX_VIEW_SEL];

   // ==========================================================
   // Flow control
   // ==========================================================
   dsr_dtr_flow u_flow (
      .core_clk (core_clk),
      .rst (rst),
      .ce (ce),
      .force_tx (force_sel),
      .auto_en (auto_sel),
      .dsr_level (mif.level[LINE_DSR]),
      .rx_near_full (rx_near_full),
      .dtr_manual (dtr_manual),
      .tx_allow (tx_allow),
      .dtr_out (dtr_out)
   );

   // ==========================================================
   // Address decode
   // ==========================================================
   // Divisor bytes overlay the data and enable registers only
   // while the latch access bit is set
   assign hit_div_low = line_control_dlab && (reg_addr == OFS_DIV_LOW);
   assign hit_div_high = line_control_dlab && (reg_addr == OFS_DIV_HIGH);
   assign hit_sample_alt = line_control_dlab && (reg_addr == OFS_SAMPLE_ALT);
   assign hit_status = (reg_addr == OFS_MODEM_STATUS);
   assign hit_special = (reg_addr == OFS_SPECIAL_FUNC);
   assign hit_tx_view = (reg_addr == OFS_TX_COUNT_VIEW);

   // Offset 16 is the sample clock only while the view select is clear
   assign sample_writable = hit_sample_alt
      || (hit_tx_view && !tx_view_sel);

   // ==========================================================
   // Write enables
   // ==========================================================
   // A frozen cycle drops the write at the register enable
   assign wr_div_low = reg_wr && hit_div_low;
   assign wr_div_high = reg_wr && hit_div_high;
   assign wr_special = reg_wr && hit_special;
   assign wr_sample = reg_wr && sample_writable;

   // ==========================================================
   // Counter views
   // ==========================================================
   assign sample_view = {4'h0, st_reg.sample};
   assign rx_view = rx_view_sel ? lsr_error_count : rx_fifo_fill_count;
   assign tx_view = tx_view_sel ? tx_fifo_fill_count : sample_view;

   // ==========================================================
   // Read multiplexer
   // ==========================================================
   // Divisor and alternate sample clock offsets answer only
   // while the latch access bit is set
   always_comb begin
      read_value = RST_RDATA;
      case (reg_addr)
         OFS_DIV_LOW: begin
            if (line_control_dlab) begin
               read_value = st_reg.div_low;
            end
         end
         OFS_DIV_HIGH: begin
            if (line_control_dlab) begin
               read_value = st_reg.div_high;
            end
         end
         OFS_SAMPLE_ALT: begin
            if (line_control_dlab) begin
               read_value = sample_view;
            end
         end
         OFS_MODEM_STATUS: begin
            read_value = modem_status;
         end
         OFS_SPECIAL_FUNC: begin
            read_value = st_reg.special;
         end
         OFS_RX_COUNT_VIEW: begin
            read_value = rx_view;
         end
         OFS_TX_COUNT_VIEW: begin
            read_value = tx_view;
         end
         default: begin
            // Unmapped offsets return zero
            read_value = RST_RDATA;
         end
      endcase
   end

   // ==========================================================
   // Baud generator inputs
   // ==========================================================
   // Code zero means sixteen, the one count that the four-bit
   // field cannot hold directly
   assign samples_value = (st_reg.sample == SAMPLE_CODE_SIXTEEN)
      ? SAMPLE_SIXTEEN : {1'b0, st_reg.sample};

   // ==========================================================
   // Next state
   // ==========================================================
   always_comb begin
      st_next = st_reg;
      st_next.rvalid = reg_rd;

      // Writes
      if (wr_div_low) begin
         st_next.div_low = reg_wdata;
      end
      if (wr_div_high) begin
         st_next.div_high = reg_wdata;
      end
      if (wr_special) begin
         // Bits 2 and 3 are read-only zeros
         st_next.special = reg_wdata & SF_WRITE_MASK;
      end
      if (wr_sample) begin
         st_next.sample = reg_wdata[SAMPLE_BITS-1:0];
      end

      // Reads
      if (reg_rd) begin
         st_next.rdata = read_value;
      end

      // Derived baud generator inputs, one cycle behind the bytes
      st_next.divisor = {st_reg.div_high, st_reg.div_low};
      st_next.samples = samples_value;
   end

   // ==========================================================
   // Registers
   // ==========================================================
   always_ff @(posedge core_clk) begin
      if (rst) begin
         st_reg <= REGS_RESET;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   assign reg_rdata = st_reg.rdata;
   assign reg_rvalid = st_reg.rvalid;
   assign baud_divisor = st_reg.divisor;
   assign oversample_count = st_reg.sample;
   assign samples_per_bit = st_reg.samples;
   assign force_tx = st_reg.special[SF_FORCE_TX];
   assign auto_dsr_dtr_en = st_reg.special[SF_AUTO_DSR_DTR];
   assign enhanced_mode = st_reg.special[SF_ENHANCED];

endmodule : uart_modem_status_and_divisor_regs

// ===== design/modem_regs_pkg.sv
// Purpose: Shared constants for the modem status, special function
//          and divisor register slice of one UART channel.
// Assumes: Byte-wide register port, offsets as printed.
// Notes:   Field positions are bit indices inside an 8-bit register.

package modem_regs_pkg;

   // ==========================================================
   // Register offsets
   // ==========================================================
   localparam logic [7:0] OFS_DIV_LOW = 8'h00;
   localparam logic [7:0] OFS_DIV_HIGH = 8'h01;
   localparam logic [7:0] OFS_SAMPLE_ALT = 8'h02;
   localparam logic [7:0] OFS_MODEM_STATUS = 8'h06;
   localparam logic [7:0] OFS_SPECIAL_FUNC = 8'h07;
   localparam logic [7:0] OFS_RX_COUNT_VIEW = 8'h15;
   localparam logic [7:0] OFS_TX_COUNT_VIEW = 8'h16;

   // ==========================================================
   // Modem line order (change flags and levels share it)
   // ==========================================================
   localparam int LINE_CTS = 0;
   localparam int LINE_DSR = 1;
   localparam int LINE_RI = 2;
   localparam int LINE_DCD = 3;
   localparam int MODEM_LINES = 4;

   // ==========================================================
   // Special function fields
   // ==========================================================
   localparam int SF_FORCE_TX = 0;
   localparam int SF_AUTO_DSR_DTR = 1;
   localparam int SF_ENHANCED = 5;
   localparam int SF_RX_VIEW_SEL = 6;
   localparam int SF_TX_VIEW_SEL = 7;
   localparam logic [7:0] SF_WRITE_MASK = 8'hf3;

   // ==========================================================
   // Sample clock field
   // ==========================================================
   localparam int SAMPLE_BITS = 4;
   localparam logic [3:0] SAMPLE_CODE_SIXTEEN = 4'h0;
   localparam logic [4:0] SAMPLE_SIXTEEN = 5'h10;

   // ==========================================================
   // Reset values
   // ==========================================================
   localparam logic [7:0] RST_DIV_BYTE = 8'h00;
   localparam logic [7:0] RST_SPECIAL = 8'h00;
   localparam logic [3:0] RST_SAMPLE = 4'h0;
   localparam logic [3:0] RST_MODEM = 4'h0;
   localparam logic RST_TX_ALLOW = 1'b1;
   localparam logic RST_DTR = 1'b0;
   localparam logic [7:0] RST_RDATA = 8'h00;

endpackage : modem_regs_pkg

// ===== design/modem_line_if.sv
// Purpose: Carries modem line levels, change flags and the read-clear
//          strobe between the register slice and its change detector.
// Assumes: Single clock domain.
// Notes:   Bit order follows the modem status register.

`timescale 1ns/1ps

interface modem_line_if;
   logic [3:0] line_in;
   logic [3:0] level;
   logic [3:0] delta;
   logic read_clear;

   modport detect (
      input line_in,
      input read_clear,
      output level,
      output delta
   );

   modport regs (
      output line_in,
      output read_clear,
      input level,
      input delta
   );
endinterface : modem_line_if

// ===== design/modem_change_detect.sv
// Purpose: Samples the four modem lines and keeps sticky change flags.
// Assumes: Lines are synchronous to core_clk.
// Notes:   A change seen while the flags are read-cleared survives.

`timescale 1ns/1ps

module modem_change_detect
   import modem_regs_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ce,
   // Line group
   modem_line_if.detect mif
);

   typedef struct packed {
      logic primed;
      logic [3:0] level;
      logic [3:0] delta;
   } detect_state_type;

   detect_state_type st_reg;
   detect_state_type st_next;
   logic [3:0] hit;

   // ==========================================================
   // Per-line change detection
   // ==========================================================
   // No edge is reported on the first sample after reset
   genvar i;
   for (i = 0; i < MODEM_LINES; i++) begin : g_line
      if (i == LINE_RI) begin : g_rise
         assign hit[i] = st_reg.primed && !st_reg.level[i] && mif.line_in[i];
      end else begin : g_any
         assign hit[i] = st_reg.primed && (st_reg.level[i] != mif.line_in[i]);
      end
   end

   always_comb begin
      st_next = st_reg;
      st_next.primed = 1'b1;
      st_next.level = mif.line_in;
      // Set wins over the read-clear in the same cycle
      st_next.delta = (st_reg.delta & ~{4{mif.read_clear}}) | hit;
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         st_reg <= '{primed: 1'b0, level: RST_MODEM, delta: RST_MODEM};
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   assign mif.level = st_reg.level;
   assign mif.delta = st_reg.delta;

endmodule : modem_change_detect

// ===== design/dsr_dtr_flow.sv
// Purpose: Transmit gate and DTR drive for DSR/DTR flow control.
// Assumes: dsr level is already sampled; rx_near_full from the FIFO.
// Notes:   Outputs are registered, so they lag their causes by one cycle.

`timescale 1ns/1ps

module dsr_dtr_flow
   import modem_regs_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ce,
   // Controls
   input wire logic force_tx,
   input wire logic auto_en,
   input wire logic dsr_level,
   input wire logic rx_near_full,
   input wire logic dtr_manual,
   // Results
   output logic tx_allow,
   output logic dtr_out
);

   typedef struct packed {
      logic tx_allow;
      logic dtr;
   } flow_state_type;

   flow_state_type st_reg;
   flow_state_type st_next;

   always_comb begin
      st_next = st_reg;
      // Forced transmission overrides any hold
      st_next.tx_allow = force_tx || !auto_en || dsr_level;
      // Drop DTR to stop the far end while our receiver is nearly full
      st_next.dtr = auto_en ? !rx_near_full : dtr_manual;
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         st_reg <= '{tx_allow: RST_TX_ALLOW, dtr: RST_DTR};
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   assign tx_allow = st_reg.tx_allow;
   assign dtr_out = st_reg.dtr;

endmodule : dsr_dtr_flow

// ===== tb/modem_regs_properties.sv
// Purpose: Port assertions for the modem status and divisor slice.
// Assumes: Lagged checks skip cycles frozen by ce; chk_read_answer expects rvalid to hold there, and the divisor checks test ce only on the write cycle.
// Notes:   Lagged outputs are judged against earlier inputs.
`timescale 1ns/1ps
module modem_regs_properties
   import modem_regs_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Register port
   input wire logic ce,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic line_control_dlab,
   // Lines
   input wire logic cts,
   input wire logic dsr,
   input wire logic ri,
   input wire logic dcd,
   input wire logic dtr_manual,
   input wire logic dtr_out,
   input wire logic rx_near_full,
   // Controls
   input wire logic [15:0] baud_divisor,
   input wire logic [3:0] oversample_count,
   input wire logic [4:0] samples_per_bit,
   input wire logic force_tx,
   input wire logic auto_dsr_dtr_en,
   input wire logic enhanced_mode,
   input wire logic tx_allow
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // =====
   // Register port
   chk_read_answer: assert property (!$past(rst)
      |-> reg_rvalid == ($past(ce) ? $past(reg_rd) : $past(reg_rvalid))) else $error("read answer mistimed");
   // Guard skips the cycle whose level copy was still in reset
   chk_status_levels: assert property (ce && reg_rd && reg_addr == OFS_MODEM_STATUS && !$past(rst)
      && $past(ce) |=> reg_rdata[7:4] == $past({dcd, ri, dsr, cts}, 2)) else $error("status levels wrong");
   chk_special_fields: assert property (ce && reg_wr && reg_addr == OFS_SPECIAL_FUNC
      |=> {force_tx, auto_dsr_dtr_en, enhanced_mode} == $past({reg_wdata[0], reg_wdata[1], reg_wdata[5]}))
      else $error("special bits not taken");
   chk_div_low: assert property (ce && reg_wr && line_control_dlab && reg_addr == OFS_DIV_LOW
      |-> ##2 baud_divisor[7:0] == $past(reg_wdata, 2)) else $error("divisor low wrong");
   chk_div_high: assert property (ce && reg_wr && line_control_dlab && reg_addr == OFS_DIV_HIGH
      |-> ##2 baud_divisor[15:8] == $past(reg_wdata, 2)) else $error("divisor high wrong");
   // =====
   // Flow control and sampling
   chk_tx_gate: assert property (!$past(rst) && !$past(rst, 2) && $past(ce) && $past(ce, 2)
      |-> tx_allow == ($past(force_tx) || !$past(auto_dsr_dtr_en) || $past(dsr, 2)))
      else $error("transmit gate wrong");
   chk_dtr_drive: assert property (!$past(rst) && $past(ce)
      |-> dtr_out == ($past(auto_dsr_dtr_en) ? !$past(rx_near_full) : $past(dtr_manual)))
      else $error("dtr level wrong");
   chk_sample_map: assert property (!$past(rst) && $past(ce)
      |-> samples_per_bit == (($past(oversample_count) == SAMPLE_CODE_SIXTEEN) ? SAMPLE_SIXTEEN
      : {1'h0, $past(oversample_count)})) else $error("sample count wrong");
endmodule : modem_regs_properties

// ===== tb/modem_far_end.sv
// Purpose: Modem side of the control lines.
// Assumes: Lines change just after a rising edge.
// Notes:   DTR is watched only; a real modem may ignore it.
`timescale 1ns/1ps
module modem_far_end (
   // Clock
   input wire logic core_clk,
   // Lines toward the device
   output logic cts = 1'h0,
   output logic dsr = 1'h0,
   output logic ri = 1'h0,
   output logic dcd = 1'h0,
   // Line from the device
   input wire logic dtr_out
);
   task automatic set_lines(input logic [3:0] v);
      @(posedge core_clk);
      {dcd, ri, dsr, cts} <= v;
   endtask : set_lines
endmodule : modem_far_end

// ===== tb/tb_uart_modem_sfr_regs.sv
// Purpose: Self-checking bench for the modem/divisor register slice.
// Assumes: Counter inputs are fixed patterns; ce drops once near the end.
// Notes:   Reads are checked one cycle after the strobe.
`timescale 1ns/1ps
module tb_uart_modem_status_and_divisor_regs;
   import modem_regs_pkg::*;
   logic core_clk, rst = 1'h1, ce = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
   logic line_control_dlab = 1'h1, dtr_manual = 1'h1, rx_near_full = 1'h0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic [7:0] rx_fifo_fill_count = 8'h3c, tx_fifo_fill_count = 8'h5a, lsr_error_count = 8'ha5;
   logic cts, dsr, ri, dcd, reg_rvalid, dtr_out, force_tx, auto_dsr_dtr_en, enhanced_mode, tx_allow;
   logic [15:0] baud_divisor;
   logic [3:0] oversample_count;
   logic [4:0] samples_per_bit;
   int n_fail = 0, check_count = 0, cycles = 0;

   uart_modem_status_and_divisor_regs i_dut (.core_clk, .rst, .ce, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
      .reg_rdata,
      .reg_rvalid, .line_control_dlab, .cts, .dsr, .ri, .dcd, .dtr_manual, .dtr_out, .rx_fifo_fill_count,
      .tx_fifo_fill_count, .lsr_error_count, .rx_near_full, .baud_divisor, .oversample_count,
      .samples_per_bit, .force_tx, .auto_dsr_dtr_en, .enhanced_mode, .tx_allow);
   modem_far_end i_far (.core_clk, .cts, .dsr, .ri, .dcd, .dtr_out);

   // =====
   // Tasks
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'h0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'h0;
      #1;
      chk("rvalid", 16'h1, {15'h0, reg_rvalid});
      chk($sformatf("reg %h", a), {8'h0, exp}, {8'h0, reg_rdata});
   endtask : rd
   task automatic idle(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : idle
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : give_verdict

   // =====
   // Clock and hang guard
   initial begin
      core_clk = 1'h0;
      forever #12.5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_fail++;
         give_verdict();
      end
   end

   // =====
   // Sequence
   initial begin
      repeat (4) @(posedge core_clk);
      rst <= 1'h0;
      idle(1);
      chk("dtr", 16'h1, {15'h0, dtr_out});
      chk("spb", 16'h10, {11'h0, samples_per_bit});
      chk("txok", 16'h1, {15'h0, tx_allow});
      rd(OFS_MODEM_STATUS, 8'h00);
      rd(OFS_SPECIAL_FUNC, 8'h00);
      rd(OFS_DIV_LOW, 8'h00);
      rd(OFS_DIV_HIGH, 8'h00);
      // All four lines rise, then fall: RI fall must not flag
      i_far.set_lines(4'hf);
      rd(OFS_MODEM_STATUS, 8'hff);
      rd(OFS_MODEM_STATUS, 8'hf0);
      i_far.set_lines(4'h0);
      rd(OFS_MODEM_STATUS, 8'h0b);
      // Change lands on the same edge as the clearing read
      fork
         i_far.set_lines(4'h1);
         rd(OFS_MODEM_STATUS, 8'h00);
      join
      rd(OFS_MODEM_STATUS, 8'h11);
      wr(OFS_SPECIAL_FUNC, 8'hff);
      rd(OFS_SPECIAL_FUNC, 8'hf3);
      chk("sf", 16'h7, {13'h0, force_tx, auto_dsr_dtr_en, enhanced_mode});
      chk("txok", 16'h1, {15'h0, tx_allow});
      rd(OFS_RX_COUNT_VIEW, 8'ha5);
      rd(OFS_TX_COUNT_VIEW, 8'h5a);
      rx_near_full <= 1'h1;
      wr(OFS_SPECIAL_FUNC, 8'h02);
      idle(2);
      chk("txok", 16'h0, {15'h0, tx_allow});
      chk("dtr", 16'h0, {15'h0, dtr_out});
      wr(OFS_SPECIAL_FUNC, 8'h00);
      rd(OFS_RX_COUNT_VIEW, 8'h3c);
      wr(OFS_TX_COUNT_VIEW, 8'h07);
      rd(OFS_TX_COUNT_VIEW, 8'h07);
      idle(2);
      chk("osc", 16'h7, {12'h0, oversample_count});
      chk("spb", 16'h7, {11'h0, samples_per_bit});
      chk("txok", 16'h1, {15'h0, tx_allow});
      wr(OFS_DIV_LOW, 8'h34);
      wr(OFS_DIV_HIGH, 8'h12);
      line_control_dlab <= 1'h0;
      wr(OFS_DIV_LOW, 8'hff);
      line_control_dlab <= 1'h1;
      rd(OFS_DIV_LOW, 8'h34);
      rd(OFS_DIV_HIGH, 8'h12);
      chk("div", 16'h1234, baud_divisor);
      rd(8'h30, 8'h00);
      wr(OFS_MODEM_STATUS, 8'hff);
      rd(OFS_MODEM_STATUS, 8'h10);
      // Frozen cycles take no write; DTR then follows the manual level
      @(posedge core_clk);
      dtr_manual <= 1'h0;
      ce <= 1'h0;
      wr(OFS_SPECIAL_FUNC, 8'h20);
      ce <= 1'h1;
      rd(OFS_SPECIAL_FUNC, 8'h00);
      chk("dtr", 16'h0, {15'h0, dtr_out});
      give_verdict();
   end
endmodule : tb_uart_modem_status_and_divisor_regs

bind uart_modem_status_and_divisor_regs modem_regs_properties i_chk (.core_clk, .rst, .ce, .reg_addr,
   .reg_wr, .reg_rd,
   .reg_wdata, .reg_rdata, .reg_rvalid, .line_control_dlab, .cts, .dsr, .ri, .dcd, .dtr_manual, .dtr_out,
   .rx_near_full, .baud_divisor, .oversample_count, .samples_per_bit, .force_tx, .auto_dsr_dtr_en,
   .enhanced_mode, .tx_allow);
